// >>> btg_master.sv
// Grant-bus master with grant pass-through and optional processor arbiter
`timescale 1ns/100ps
module btg_master
  import btg_pkg::*;
#(
  parameter int unsigned HOLD  = HOLD_CYC,
  parameter int unsigned TMO   = GRANT_TMO_CYC,
  parameter int unsigned NINTR = INTR_LEVELS
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             xfer_start,
  output logic                  xfer_busy,
  output logic                  xfer_done,
  output logic                  dma_request,
  input  wire logic             dma_grant_in,
  output logic                  dma_grant_out,
  input  wire logic             select_ack_in,
  output logic                  select_ack_out,
  output logic                  select_ack_oe_n,
  input  wire logic             first_bus,
  input  wire logic [NINTR-1:0] intr_pending,
  input  wire logic [NINTR-1:0] intr_grant_in,
  output logic      [NINTR-1:0] intr_grant_out,
  input  wire logic             cpu_enable,
  input  wire logic             bus_dma_request,
  output logic                  cpu_grant,
  output logic                  cpu_timeout
);
  typedef struct packed {
    btg_mstate_t      st;
    logic             busy;
    logic             done;
    logic             req;
    logic             gnt_out;
    logic             sack;
    logic [NINTR-1:0] igrant;
    logic             cgrant;
    logic             ctmo;
    logic [CNT_W-1:0] ctimer;
  } btg_state_t;

  btg_state_t s_reg;
  btg_state_t s_next;

  logic hold_load;
  logic hold_zero;
  logic gap_zero;

  // Hold time of bus ownership once the grant has been claimed
  btg_count #(.W(CNT_W)) u_hold (
    .clk   (clk),
    .rst   (rst),
    .load  (hold_load),
    .value (CNT_W'(HOLD)),
    .run   (s_reg.st == BTG_OWN),
    .zero  (hold_zero)
  );

  // Bus acknowledge must be gone for the gap before the processor grants again
  btg_count #(.W(CNT_W)) u_gap (
    .clk   (clk),
    .rst   (rst),
    .load  (select_ack_in),
    .value (CNT_W'(SACK_GAP_CYC)),
    .run   (1'b1),
    .zero  (gap_zero)
  );

  assign hold_load = (s_reg.st == BTG_CLAIM) && !dma_grant_in;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      BTG_IDLE: begin
        if (xfer_start) begin
          s_next.st   = BTG_REQ;
          s_next.busy = 1'b1;
          s_next.req  = 1'b1;
        end
      end
      BTG_REQ: begin
        // Nothing proceeds until the grant reaches us; the grant is then ours, not passed on
        if (dma_grant_in && !select_ack_in) begin
          s_next.st   = BTG_CLAIM;
          s_next.sack = 1'b1;
          s_next.req  = 1'b0;
        end
      end
      BTG_CLAIM: begin
        if (!dma_grant_in) begin
          s_next.st = BTG_OWN;
        end
      end
      BTG_OWN: begin
        if (hold_zero) begin
          s_next.st   = BTG_END;
          s_next.sack = 1'b0;
        end
      end
      BTG_END: begin
        s_next.st   = BTG_IDLE;
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
      default: begin
        s_next.st = BTG_IDLE;
      end
    endcase

    // A grant goes on down the chain only if our next state is BTG_IDLE
    s_next.gnt_out = dma_grant_in && (s_next.st == BTG_IDLE);

    // Second bus: never interrupts here, so the grants go by untouched
    if (first_bus) begin
      s_next.igrant = intr_grant_in & ~intr_pending;
    end else begin
      s_next.igrant = intr_grant_in;
    end

    // Processor role: grant one request, drop it on acknowledge or after the timeout
    if (!cpu_enable) begin
      s_next.cgrant = 1'b0;
      s_next.ctmo   = 1'b0;
      s_next.ctimer = '0;
    end else if (s_reg.cgrant) begin
      if (select_ack_in) begin
        s_next.cgrant = 1'b0;
        s_next.ctimer = '0;
      end else if (s_reg.ctimer == CNT_W'(TMO - 1)) begin
        s_next.cgrant = 1'b0;
        s_next.ctmo   = 1'b1;
        s_next.ctimer = '0;
      end else begin
        s_next.ctimer = s_reg.ctimer + CNT_W'(1);
      end
    end else if (bus_dma_request && !select_ack_in && gap_zero) begin
      s_next.cgrant = 1'b1;
      s_next.ctmo   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg    <= '0;
      s_reg.st <= BTG_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign xfer_busy       = s_reg.busy;
  assign xfer_done       = s_reg.done;
  assign dma_request     = s_reg.req;
  assign dma_grant_out   = s_reg.gnt_out;
  assign select_ack_out  = s_reg.sack;
  assign select_ack_oe_n = ~s_reg.sack;
  assign intr_grant_out  = s_reg.igrant;
  assign cpu_grant       = s_reg.cgrant;
  assign cpu_timeout     = s_reg.ctmo;

  sequence s_waiting;
    dma_request && !dma_grant_in;
  endsequence

  sequence s_claimed;
    select_ack_out && !dma_request && !dma_grant_out;
  endsequence

  a_req_holds: assert property (@(posedge clk) disable iff (rst)
    s_waiting |=> dma_request || xfer_done)
    else $error("dma request dropped before grant");

  a_grant_claim: assert property (@(posedge clk) disable iff (rst)
    (s_waiting ##1 (dma_grant_in && !select_ack_in && s_reg.st == BTG_REQ)) |=> s_claimed)
    else $error("grant not claimed after request");

  a_grant_pass: assert property (@(posedge clk) disable iff (rst)
    (dma_grant_in && !xfer_busy && !xfer_start) |=> dma_grant_out)
    else $error("unclaimed grant not passed on");

  a_intr_pass: assert property (@(posedge clk) disable iff (rst)
    first_bus |=> intr_grant_out == ($past(intr_grant_in) & ~$past(intr_pending)))
    else $error("interrupt grant pass-through wrong");

  a_cpu_drop: assert property (@(posedge clk) disable iff (rst)
    (cpu_grant && select_ack_in) |=> !cpu_grant)
    else $error("processor grant not dropped on acknowledge");
endmodule : btg_master

// >>> btg_pkg.sv
// Shared constants and types for the grant-bus master and processor arbiter
package btg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SACK_GAP_NS   = 100;
  localparam int unsigned SACK_GAP_CYC  = (SACK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GRANT_TMO_NS  = 10000;
  localparam int unsigned GRANT_TMO_CYC = GRANT_TMO_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC      = 8;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned INTR_LEVELS   = 4;

  typedef enum logic [2:0] {
    BTG_IDLE,
    BTG_REQ,
    BTG_CLAIM,
    BTG_OWN,
    BTG_END
  } btg_mstate_t;
endpackage : btg_pkg

// >>> btg_count.sv
// Loadable down counter with a zero flag
`timescale 1ns/100ps
module btg_count
  import btg_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         run,
  output logic              zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } btg_cnt_st_t;

  btg_cnt_st_t s_reg;
  btg_cnt_st_t s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = value;
    end else if (run && s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign zero = (s_reg.cnt == '0);
endmodule : btg_count

// >>> btg_term.sv
// Terminator model: dma arbiter, acknowledge watchdog, end-of-bus acknowledge
`timescale 1ns/100ps
module btg_term
  import btg_pkg::*;
#(
  parameter int unsigned TMO = 20
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       arbiter_enable_strap,
  input  wire logic       end_of_bus_strap,
  input  wire logic       processor_present_strap,
  input  wire logic       dc_power_low,
  input  wire logic       req,
  input  wire logic       end_grant,
  input  wire logic [3:0] end_intr,
  input  wire logic       sack,
  output logic            grant,
  output logic            end_ack,
  output logic            missing_ack_flag,
  output logic            bus_init,
  output logic            illegal_cfg
);
  logic [1:0]  gap_reg;
  logic [1:0]  age_reg;
  logic [15:0] tmr_reg;
  logic        pend_reg;
  logic        ack;
  assign ack = sack | missing_ack_flag;
  assign bus_init = arbiter_enable_strap & dc_power_low;
  assign illegal_cfg = arbiter_enable_strap & end_of_bus_strap;
  always_ff @(posedge clk) begin
    if (rst) begin
      {grant, end_ack, missing_ack_flag, gap_reg, age_reg, tmr_reg, pend_reg} <= '0;
    end else begin
      // Two idle edges make the 100 ns gap at this clock
      gap_reg <= ack ? 2'h0 : (gap_reg == 2'h2 ? gap_reg : gap_reg + 2'h1);
      age_reg <= !ack ? 2'h0 : (age_reg == 2'h2 ? age_reg : age_reg + 2'h1);
      // A request seen during acknowledge is kept until it has been granted
      pend_reg <= arbiter_enable_strap && !grant && (pend_reg || req);
      grant <= arbiter_enable_strap && !ack && (grant || ((req || pend_reg) && gap_reg == 2'h2));
      tmr_reg <= (age_reg == 2'h2) ? 16'h0 : tmr_reg + 16'(grant);
      if (age_reg == 2'h2) missing_ack_flag <= 1'b0;
      else if (tmr_reg == 16'(TMO)) missing_ack_flag <= 1'b1;
      end_ack <= end_of_bus_strap && (end_grant || (processor_present_strap && |end_intr));
    end
  end
endmodule : btg_term

// >>> tb_top.sv
// Self-checking bench: grant-bus master against the terminator model
`timescale 1ns/100ps
module tb_top
  import btg_pkg::*;
();
  localparam int unsigned TMO = 20;
  logic clk, rst, xfer_start, first_bus, cpu_enable, bus_dma_request, other_req;
  logic [3:0] intr_pending, intr_grant_in, intr_grant_out;
  logic xfer_busy, xfer_done, dma_request, dma_grant_in, dma_grant_out, select_ack_in;
  logic select_ack_out, select_ack_oe_n, cpu_grant, cpu_timeout, end_ack, missing_ack_flag;
  logic arbiter_enable_strap, end_of_bus_strap, processor_present_strap, dc_power_low;
  int num_errors, comparisons, seed, n;
  logic [3:0] exp_q[$];
  logic [6:0] mon;
  // Wired-or acknowledge line: master drives only while its enable is low
  assign select_ack_in = (select_ack_out & ~select_ack_oe_n) | end_ack;
  assign mon = {dma_grant_in, cpu_timeout, cpu_grant, end_ack, dma_grant_out, xfer_done, dma_request};
  btg_master #(.TMO(TMO)) i_btg_master (
    .clk, .rst, .xfer_start, .xfer_busy, .xfer_done, .dma_request, .dma_grant_in, .dma_grant_out,
    .select_ack_in, .select_ack_out, .select_ack_oe_n, .first_bus, .intr_pending, .intr_grant_in,
    .intr_grant_out, .cpu_enable, .bus_dma_request, .cpu_grant, .cpu_timeout);
  btg_term #(.TMO(TMO)) i_btg_term (
    .clk, .rst, .arbiter_enable_strap, .end_of_bus_strap, .processor_present_strap, .dc_power_low,
    .req(dma_request | other_req), .end_grant(dma_grant_out | cpu_grant), .end_intr(intr_grant_out),
    .sack(select_ack_in), .grant(dma_grant_in), .end_ack, .missing_ack_flag, .bus_init(), .illegal_cfg());
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Sample on the rising edge, so values seen are those settled in the cycle before
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int cnt);
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(posedge clk);
      if (mon[sel] === lvl) return;
    end
    num_errors++;
    $display("mismatch at %0t: wait on %0d ran out", $time, sel);
    print_verdict();
  endtask : wait_sig
  task automatic xfer();
    int k;
    xfer_start <= 1'b1;
    @(posedge clk);
    xfer_start <= 1'b0;
    wait_sig(6, 1'b1, 20, k);
    check({dma_request, select_ack_oe_n}, 2'h3);
    @(posedge clk);
    check({dma_request, select_ack_oe_n, select_ack_out, xfer_busy}, 4'h3);
    wait_sig(1, 1'b1, 40, k);
    check({dma_request, select_ack_oe_n}, 2'h1);
  endtask : xfer
  // Foreign request is held until its grant is seen; n counts how long the grant then stands
  task automatic other_grant();
    int k;
    other_req <= 1'b1;
    wait_sig(6, 1'b1, 10, k);
    other_req <= 1'b0;
    wait_sig(2, 1'b1, 5, k);
    wait_sig(6, 1'b0, TMO + 10, n);
  endtask : other_grant
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    if (exp_q.size() > 0) check(intr_grant_out, exp_q.pop_front());
  end
  initial begin
    {xfer_start, first_bus, cpu_enable, bus_dma_request, other_req, intr_pending, intr_grant_in} = '0;
    {end_of_bus_strap, processor_present_strap, arbiter_enable_strap, dc_power_low} = 4'h3;
    rst = 1'b1;
    seed = 93505;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({select_ack_oe_n, dma_request, xfer_busy, cpu_grant}, 5'h08);
    repeat (2) xfer();
    end_of_bus_strap <= 1'b1;
    other_grant();
    check(n < TMO, 1'b1);
    end_of_bus_strap <= 1'b0;
    other_grant();
    check(n >= TMO, 1'b1);
    xfer();
    arbiter_enable_strap <= 1'b0;
    other_req <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      check(dma_grant_out, 1'b0);
    end
    {other_req, end_of_bus_strap, cpu_enable, bus_dma_request} <= 4'h7;
    wait_sig(4, 1'b1, 5, n);
    wait_sig(4, 1'b0, 10, n);
    check(cpu_timeout, 1'b0);
    end_of_bus_strap <= 1'b0;
    wait_sig(5, 1'b1, TMO + 20, n);
    check(cpu_grant, 1'b0);
    {cpu_enable, bus_dma_request} <= 2'h0;
    repeat (2) @(posedge clk);
    check({cpu_grant, cpu_timeout}, 2'h0);
    repeat (60) begin
      @(posedge clk);
      exp_q.push_back(first_bus ? intr_grant_in & ~intr_pending : intr_grant_in);
      {first_bus, intr_pending, intr_grant_in} <= 9'($random(seed));
    end
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule : tb_top
